// ---- uhf_cfg.svh ----
// register offsets, field positions, reset values and codes of the uart host block
`ifndef UHF_CFG_SVH
`define UHF_CFG_SVH

// register indices; byte address is four times the index
`define UHF_IDX_DATA 6'h00
`define UHF_IDX_IEN 6'h01
`define UHF_IDX_ISRC 6'h02
`define UHF_IDX_LFMT 6'h03
`define UHF_IDX_MODE 6'h04
`define UHF_IDX_EVST 6'h08
`define UHF_IDX_EVMSK 6'h09
`define UHF_IDX_LEVEL 6'h0a

// field positions
`define UHF_LFMT_DIV_SEL 7
`define UHF_IEN_RXRDY 0
`define UHF_IEN_TXEMP 1
`define UHF_IEN_RXERR 2
`define UHF_IEN_MODEM 3
`define UHF_IEN_XOFF 4
`define UHF_IEN_RTS 5
`define UHF_IEN_CTS 6
`define UHF_EV_TXDROP 0
`define UHF_EV_RXOVR 1
`define UHF_EV_RXUNDER 2

// reset values
`define UHF_IEN_RST 8'h00
`define UHF_LFMT_RST 8'h00
`define UHF_QCTL_RST 8'h00
`define UHF_DIV_RST 8'h00

// interrupt source codes, highest priority first
`define UHF_ISRC_NONE 8'hc1
`define UHF_ISRC_RXERR 8'hc6
`define UHF_ISRC_RXRDY 8'hc4
`define UHF_ISRC_RXTMO 8'hcc
`define UHF_ISRC_TXEMP 8'hc2
`define UHF_ISRC_MODEM 8'hc0
`define UHF_ISRC_XOFF 8'hd0
`define UHF_ISRC_CTSRTS 8'he0

// receive trigger thresholds, normal then enhanced
`define UHF_RXT_N0 1
`define UHF_RXT_N1 4
`define UHF_RXT_N2 8
`define UHF_RXT_N3 14
`define UHF_RXT_E0 15
`define UHF_RXT_E1 31
`define UHF_RXT_E2 63
`define UHF_RXT_E3 111
// transmit trigger thresholds, enhanced mode
`define UHF_TXT_E0 16
`define UHF_TXT_E1 32
`define UHF_TXT_E2 64
`define UHF_TXT_E3 112

`endif

// ---- uhf_fifo.sv ----
// byte queue with registered head data
`timescale 1ns/1ps
module uhf_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 128,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic flush_i,
    input wire logic [CW-1:0] cap_i,
    // push side
    input wire logic push_i,
    input wire logic [W-1:0] wdata_i,
    // pop side
    input wire logic pop_i,
    output logic [W-1:0] rdata_o,
    // state
    output logic [CW-1:0] count_o,
    output logic full_o,
    output logic empty_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic push_ok;
    logic pop_ok;

    // capacity may be below depth, one entry when queueing is off
    assign full_o = (count_o >= cap_i);
    assign empty_o = (count_o == '0);
    assign push_ok = push_i && !full_o;
    assign pop_ok = pop_i && !empty_o;
    assign next_rd_ptr = pop_ok ? AW'(rd_ptr + 1'b1) : rd_ptr;

    // storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (push_ok) begin
            mem[wr_ptr] <= wdata_i;
        end
    end

    // pointers and fill count; flush wins over traffic
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count_o <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count_o <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            rd_ptr <= next_rd_ptr;
            count_o <= CW'(count_o + CW'(push_ok) - CW'(pop_ok));
        end
    end

    // head register; write-through when a byte lands on the new head
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (push_ok && (wr_ptr == next_rd_ptr)) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem[next_rd_ptr];
        end
    end

endmodule // uhf_fifo

// ---- uhf_pkg.sv ----
// types shared by the uart host block
package uhf_pkg;

    // queue control write fields
    typedef struct packed {
        logic [1:0] rx_trig;
        logic [1:0] tx_trig;
        logic rsvd;
        logic tx_flush;
        logic rx_flush;
        logic fifo_en;
    } uhf_qctl_t;

    // pending levels from the serial side
    typedef struct packed {
        logic rx_err;
        logic rx_timeout;
        logic modem;
        logic xoff;
        logic rts_dtr;
        logic cts_dsr;
    } uhf_src_t;

    // winning interrupt source
    typedef enum logic [2:0] {
        SRC_NONE, SRC_RXERR, SRC_RXRDY, SRC_RXTMO, SRC_TXEMP, SRC_MODEM, SRC_XOFF, SRC_CTSRTS
    } uhf_src_id_t;

endpackage

// ---- uhf_regs.sv ----
// uart channel host registers: data queues, interrupt enable/source, queue control
// Behaviour
// - A read of the receive data register returns the oldest queued byte and removes it.
// - A write to the transmit data register appends the byte at the queue tail.
// - A transmit data write while the transmit queue is full is dropped, queue untouched.
// - Interrupt enable bits 0..3 gate rx ready, tx empty, rx line status, modem; reset 0.
// - Enable bits 4..6 gate xoff, rts/dtr and cts/dsr; bit 7 is plain storage; reset 0.
// - The interrupt source register is read-only, resets to c1, bit 0 low when pending.
// - The source register shows the highest-priority pending code, c6 c4 cc c2 c0 d0 e0.
// - Queue control bit 0 turns queueing on with one and off with zero, reset 0.
// - Writing one to queue control bit 1 empties the receive queue once.
// - Writing one to queue control bit 2 empties the transmit queue once.
// - In enhanced mode the tx trigger field picks 16, 32, 64 or 112 entries.
// - Outside enhanced mode the rx trigger field picks 1, 4, 8 or 14 bytes.
// - In enhanced mode the rx trigger field picks 15, 31, 63 or 111 bytes.
// - With the divisor-select bit set, offsets 0 and 1 reach the divisor latch.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "uhf_cfg.svh"
module uhf_regs
    import uhf_pkg::*;
#(
    parameter int DEPTH = 128,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    // receive byte stream from the serial receiver
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic rx_ready_o,
    // transmit byte stream to the serial transmitter
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // pending levels from the line and modem logic
    input wire uhf_src_t src_i,
    // configuration towards the channel
    output logic [7:0] line_format_o,
    output logic [15:0] divisor_o,
    output logic fifo_enable_o,
    output logic enhanced_o,
    // interrupt
    output logic irq_o
);

    logic [5:0] idx;
    logic access;
    logic wr_en;
    logic rd_done;
    logic div_sel;
    logic [7:0] interrupt_enable;
    logic [7:0] line_format;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic enhanced;
    uhf_qctl_t qctl;
    uhf_qctl_t wq;
    logic [2:0] event_status;
    logic [2:0] event_mask;
    logic [2:0] event_set;
    logic [7:0] interrupt_source;
    uhf_src_id_t top_src;
    logic [CW-1:0] cap;
    logic [CW-1:0] rx_count;
    logic [CW-1:0] tx_count;
    logic [CW-1:0] rx_thresh;
    logic [CW-1:0] tx_thresh;
    logic [7:0] rx_head;
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
    logic rx_pop;
    logic tx_push;
    logic rx_flush;
    logic tx_flush;
    logic rx_ready_pend;
    logic tx_low_pend;
    logic [31:0] next_dat;

    // bus decode; register index sits above the byte lanes
    assign idx = adr_i[7:2];
    assign access = cyc_i && stb_i;
    assign wr_en = access && ack_o && we_i && sel_i[0];
    assign rd_done = access && ack_o && !we_i;
    assign div_sel = line_format[`UHF_LFMT_DIV_SEL];
    assign wq = uhf_qctl_t'(dat_i[7:0]);

    // ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= access && !ack_o;
        end
    end

    // effective queue size: one holding byte while queueing is off
    assign cap = qctl.fifo_en ? CW'(DEPTH) : CW'(1);

    assign rx_pop = rd_done && (idx == `UHF_IDX_DATA) && !div_sel;
    assign tx_push = wr_en && (idx == `UHF_IDX_DATA) && !div_sel;
    assign rx_flush = wr_en && (idx == `UHF_IDX_ISRC) && wq.rx_flush;
    assign tx_flush = wr_en && (idx == `UHF_IDX_ISRC) && wq.tx_flush;

    // receive queue, filled by the serial receiver
    uhf_fifo #(
        .W(8),
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_rx_q (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(rx_flush),
        .cap_i(cap),
        .push_i(rx_valid_i),
        .wdata_i(rx_data_i),
        .pop_i(rx_pop),
        .rdata_o(rx_head),
        .count_o(rx_count),
        .full_o(rx_full),
        .empty_o(rx_empty)
    );

    uhf_fifo #(
        .W(8),
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_tx_q (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(tx_flush),
        .cap_i(cap),
        .push_i(tx_push),
        .wdata_i(dat_i[7:0]),
        .pop_i(tx_valid_o && tx_ready_i),
        .rdata_o(tx_data_o),
        .count_o(tx_count),
        .full_o(tx_full),
        .empty_o(tx_empty)
    );

    // serial side handshakes; back-pressure reaches the receiver
    assign rx_ready_o = !rx_full;
    assign tx_valid_o = !tx_empty;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            interrupt_enable <= `UHF_IEN_RST;
        end else if (wr_en && (idx == `UHF_IDX_IEN) && !div_sel) begin
            interrupt_enable <= dat_i[7:0];
        end
    end

    // divisor latch behind the data and interrupt enable offsets
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            divisor_low <= `UHF_DIV_RST;
            divisor_high <= `UHF_DIV_RST;
        end else if (wr_en && div_sel) begin
            if (idx == `UHF_IDX_DATA) begin
                divisor_low <= dat_i[7:0];
            end
            if (idx == `UHF_IDX_IEN) begin
                divisor_high <= dat_i[7:0];
            end
        end
    end

    // line format and mode registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_format <= `UHF_LFMT_RST;
            enhanced <= 1'b0;
        end else begin
            if (wr_en && (idx == `UHF_IDX_LFMT)) begin
                line_format <= dat_i[7:0];
            end
            if (wr_en && (idx == `UHF_IDX_MODE)) begin
                enhanced <= dat_i[0];
            end
        end
    end

    // queue control; flush bits never stored, so they self-clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            qctl <= uhf_qctl_t'(`UHF_QCTL_RST);
        end else if (wr_en && (idx == `UHF_IDX_ISRC)) begin
            qctl.fifo_en <= wq.fifo_en;
            qctl.tx_trig <= wq.tx_trig;
            qctl.rx_trig <= wq.rx_trig;
        end
    end

    always_comb begin
        if (!qctl.fifo_en) begin
            rx_thresh = CW'(1);
        end else if (enhanced) begin
            case (qctl.rx_trig)
                2'b00: rx_thresh = CW'(`UHF_RXT_E0);
                2'b01: rx_thresh = CW'(`UHF_RXT_E1);
                2'b10: rx_thresh = CW'(`UHF_RXT_E2);
                default: rx_thresh = CW'(`UHF_RXT_E3);
            endcase
        end else begin
            case (qctl.rx_trig)
                2'b00: rx_thresh = CW'(`UHF_RXT_N0);
                2'b01: rx_thresh = CW'(`UHF_RXT_N1);
                2'b10: rx_thresh = CW'(`UHF_RXT_N2);
                default: rx_thresh = CW'(`UHF_RXT_N3);
            endcase
        end
    end

    // transmit threshold, as free entries wanted
    always_comb begin
        case (qctl.tx_trig)
            2'b00: tx_thresh = CW'(`UHF_TXT_E0);
            2'b01: tx_thresh = CW'(`UHF_TXT_E1);
            2'b10: tx_thresh = CW'(`UHF_TXT_E2);
            default: tx_thresh = CW'(`UHF_TXT_E3);
        endcase
    end

    // pending levels of the queue sources
    assign rx_ready_pend = (rx_count >= rx_thresh);
    // outside enhanced queueing only a drained queue counts as empty
    assign tx_low_pend = (enhanced && qctl.fifo_en)
        ? (CW'(cap - tx_count) >= tx_thresh) : tx_empty;

    always_comb begin
        if (src_i.rx_err && interrupt_enable[`UHF_IEN_RXERR]) begin
            top_src = SRC_RXERR;
        end else if (rx_ready_pend && interrupt_enable[`UHF_IEN_RXRDY]) begin
            top_src = SRC_RXRDY;
        end else if (src_i.rx_timeout && interrupt_enable[`UHF_IEN_RXRDY]) begin
            top_src = SRC_RXTMO;
        end else if (tx_low_pend && interrupt_enable[`UHF_IEN_TXEMP]) begin
            top_src = SRC_TXEMP;
        end else if (src_i.modem && interrupt_enable[`UHF_IEN_MODEM]) begin
            top_src = SRC_MODEM;
        end else if (src_i.xoff && interrupt_enable[`UHF_IEN_XOFF]) begin
            top_src = SRC_XOFF;
        end else if ((src_i.rts_dtr && interrupt_enable[`UHF_IEN_RTS])
                || (src_i.cts_dsr && interrupt_enable[`UHF_IEN_CTS])) begin
            top_src = SRC_CTSRTS;
        end else begin
            top_src = SRC_NONE;
        end
    end

    // source code; bit 0 low only while something is pending
    always_comb begin
        case (top_src)
            SRC_RXERR: interrupt_source = `UHF_ISRC_RXERR;
            SRC_RXRDY: interrupt_source = `UHF_ISRC_RXRDY;
            SRC_RXTMO: interrupt_source = `UHF_ISRC_RXTMO;
            SRC_TXEMP: interrupt_source = `UHF_ISRC_TXEMP;
            SRC_MODEM: interrupt_source = `UHF_ISRC_MODEM;
            SRC_XOFF: interrupt_source = `UHF_ISRC_XOFF;
            SRC_CTSRTS: interrupt_source = `UHF_ISRC_CTSRTS;
            default: interrupt_source = `UHF_ISRC_NONE;
        endcase
    end

    // sticky queue events: dropped write, receive overrun, empty read
    assign event_set[`UHF_EV_TXDROP] = tx_push && tx_full;
    assign event_set[`UHF_EV_RXOVR] = rx_valid_i && rx_full;
    // empty read only flagged, data is stale
    assign event_set[`UHF_EV_RXUNDER] = rx_pop && rx_empty;

    // event status, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            event_status <= 3'h0;
        end else if (wr_en && (idx == `UHF_IDX_EVST)) begin
            event_status <= (event_status & ~dat_i[2:0]) | event_set;
        end else begin
            event_status <= event_status | event_set;
        end
    end

    // event mask, one enables the bit onto the interrupt
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            event_mask <= 3'h0;
        end else if (wr_en && (idx == `UHF_IDX_EVMSK)) begin
            event_mask <= dat_i[2:0];
        end
    end

    // level interrupt from sources and sticky events
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (top_src != SRC_NONE) || |(event_status & event_mask);
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        next_dat = 32'h0;
        case (idx)
            `UHF_IDX_DATA: next_dat[7:0] = div_sel ? divisor_low : rx_head;
            `UHF_IDX_IEN: next_dat[7:0] = div_sel ? divisor_high : interrupt_enable;
            `UHF_IDX_ISRC: next_dat[7:0] = interrupt_source;
            `UHF_IDX_LFMT: next_dat[7:0] = line_format;
            `UHF_IDX_MODE: next_dat[0] = enhanced;
            `UHF_IDX_EVST: next_dat[2:0] = event_status;
            `UHF_IDX_EVMSK: next_dat[2:0] = event_mask;
            `UHF_IDX_LEVEL: next_dat = {8'h0, 8'(tx_count), 8'h0, 8'(rx_count)};
            default: next_dat = 32'h0;
        endcase
    end

    // read data captured with the ack
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (access && !ack_o && !we_i) begin
            dat_o <= next_dat;
        end
    end

    // configuration outputs held in flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_format_o <= `UHF_LFMT_RST;
            divisor_o <= 16'h0;
            fifo_enable_o <= 1'b0;
            enhanced_o <= 1'b0;
        end else begin
            line_format_o <= line_format;
            divisor_o <= {divisor_high, divisor_low};
            fifo_enable_o <= qctl.fifo_en;
            enhanced_o <= enhanced;
        end
    end

endmodule // uhf_regs

// ---- uhf_regs_asserts.sv ----
// assertion checker for the uart host registers, bound to uhf_regs
`timescale 1ns/1ps
module uhf_regs_asserts (
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // streams and configuration
    input wire logic rx_ready_o,
    input wire logic tx_valid_o,
    input wire logic [7:0] line_format_o,
    input wire logic [15:0] divisor_o,
    input wire logic fifo_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // accepted accesses; dsel lags a cycle, harmless since accesses are 3 apart
    wire logic rd = cyc_i && stb_i && ack_o && !we_i;
    wire logic wr = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    wire logic [5:0] idx = adr_i[7:2];
    wire logic dsel = line_format_o[7];
    AST_ACK_ONCE: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse one cycle after request");
    AST_SRC_FORM: assert property (rd && idx == 6'h02 |-> dat_o[31:6] == 26'h3
        && (!dat_o[0] || dat_o[7:0] == 8'hc1)) else $error("bad interrupt source form");
    AST_SRC_CODE: assert property (rd && idx == 6'h02 |-> dat_o[7:0] inside
        {8'hc1, 8'hc6, 8'hc4, 8'hcc, 8'hc2, 8'hc0, 8'hd0, 8'he0}) else $error("bad source code");
    AST_TX_PUSH: assert property (wr && idx == 6'h00 && !dsel && !tx_valid_o |=> tx_valid_o)
        else $error("transmit write not queued");
    AST_RX_POP: assert property (rd && idx == 6'h00 && !dsel && !rx_ready_o |=> rx_ready_o)
        else $error("receive read did not free an entry");
    AST_RX_FLUSH: assert property (wr && idx == 6'h02 && dat_i[1] |=> rx_ready_o)
        else $error("receive flush left queue full");
    AST_TX_FLUSH: assert property (wr && idx == 6'h02 && dat_i[2] |=> !tx_valid_o)
        else $error("transmit flush left bytes");
    AST_FIFO_EN: assert property (wr && idx == 6'h02 |=> ##1 fifo_enable_o == $past(dat_i[0], 2))
        else $error("queueing enable not taken");
    AST_DIV_LOW: assert property (wr && idx == 6'h00 && dsel
        |=> ##1 divisor_o[7:0] == $past(dat_i[7:0], 2)) else $error("divisor low not written");
    AST_DIV_HIGH: assert property (wr && idx == 6'h01 && dsel
        |=> ##1 divisor_o[15:8] == $past(dat_i[7:0], 2)) else $error("divisor high not written");
endmodule // uhf_regs_asserts

bind uhf_regs uhf_regs_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
    .line_format_o(line_format_o), .divisor_o(divisor_o), .fifo_enable_o(fifo_enable_o));

// ---- uhf_regs_bench.sv ----
// self-checking bench for the uart host registers
`timescale 1ns/1ps
`include "uhf_cfg.svh"
module uhf_regs_bench;
    import uhf_pkg::*;
    logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, irq_o, fifo_enable_o, enhanced_o;
    logic rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] adr_i, rx_data, tx_data, line_format_o;
    logic [31:0] dat_i, dat_o, q;
    logic [15:0] divisor_o;
    logic [3:0] sel_i;
    uhf_src_t src_i;
    int err_count, compares, cycles, i, k, m;
    // rows: write, address, data, expected read
    localparam logic [24:0] ROWS [9] = '{{1'b0, 8'h08, 8'h00, 8'hc1}, {1'b0, 8'h04, 8'h00, 8'h00},
        {1'b1, 8'h04, 8'hff, 8'h00}, {1'b0, 8'h04, 8'h00, 8'hff}, {1'b0, 8'h08, 8'h00, 8'hc2},
        {1'b1, 8'h04, 8'h00, 8'h00}, {1'b0, 8'hfc, 8'h00, 8'h00}, {1'b1, 8'h0c, 8'h03, 8'h00},
        {1'b0, 8'h0c, 8'h00, 8'h03}};
    // source levels and the code they should win with
    localparam logic [13:0] PRI [8] = '{{6'h20, 8'hc6}, {6'h00, 8'hc4}, {6'h10, 8'hcc},
        {6'h00, 8'hc2}, {6'h08, 8'hc0}, {6'h04, 8'hd0}, {6'h02, 8'he0}, {6'h01, 8'he0}};
    localparam int RXT [8] = '{`UHF_RXT_N0, `UHF_RXT_N1, `UHF_RXT_N2, `UHF_RXT_N3,
        `UHF_RXT_E0, `UHF_RXT_E1, `UHF_RXT_E2, `UHF_RXT_E3};
    localparam int TXT [4] = '{`UHF_TXT_E0, `UHF_TXT_E1, `UHF_TXT_E2, `UHF_TXT_E3};
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    uhf_regs uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready), .src_i(src_i),
        .line_format_o(line_format_o), .divisor_o(divisor_o), .fifo_enable_o(fifo_enable_o),
        .enhanced_o(enhanced_o), .irq_o(irq_o));
    uhf_serial_model sm (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .tx_ready_o(tx_ready));
    task close_out;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t expected %h got %h", $time, e, g);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 8'h00);
        chk(e, q);
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // hang guard, well above the few thousand cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, src_i} = '0;
        rst_i = 1'b1;
        sel_i = 4'h1;
        err_count = 0;
        compares = 0;
        cycles = 0;
        wt(16);
        rst_i <= 1'b0;
        wt(1);
        chk(32'h0, irq_o);
        for (i = 0; i < 9; i++) begin
            wb(ROWS[i][24], ROWS[i][23:16], ROWS[i][15:8]);
            if (!ROWS[i][24]) chk({24'h0, ROWS[i][7:0]}, q);
        end
        // priority walk with every source enabled
        wb(1'b1, 8'h04, 8'hff);
        sm.send(8'h3c);
        for (i = 0; i < 8; i++) begin
            if (i == 2) rd(8'h00, 32'h3c);
            if (i == 4) sm.stall <= 1'b1;
            if (i == 4) wb(1'b1, 8'h00, 8'h11);
            src_i <= PRI[i][13:8];
            wt(3);
            rd(8'h08, {24'h0, PRI[i][7:0]});
        end
        chk(32'h1, irq_o);
        wb(1'b1, 8'h04, 8'h00);
        wt(2);
        chk(32'h0, irq_o);
        src_i <= '0;
        sm.stall <= 1'b0;
        wt(4);
        sm.got.delete();
        // fill the transmit queue past full while the line stalls
        wb(1'b1, 8'h08, 8'h01);
        wt(2);
        chk(32'h1, fifo_enable_o);
        sm.stall <= 1'b1;
        for (i = 0; i < 129; i++) wb(1'b1, 8'h00, i[7:0]);
        rd(8'h28, 32'h00800000);
        sm.stall <= 1'b0;
        wt(200);
        chk(128, sm.got.size());
        chk(32'h7f, sm.got[127]);
        // drop event: raise, mask, clear
        rd(8'h20, 32'h1);
        wb(1'b1, 8'h24, 8'h01);
        wt(2);
        chk(32'h1, irq_o);
        wb(1'b1, 8'h20, 8'h01);
        wt(2);
        chk(32'h0, irq_o);
        // trigger levels, normal then enhanced
        for (m = 0; m < 2; m++) begin
            wb(1'b1, 8'h10, m[7:0]);
            wt(2);
            chk(m, enhanced_o);
            for (k = 0; k < 4; k++) begin
                wb(1'b1, 8'h08, {k[1:0], k[1:0], 4'h1});
                wb(1'b1, 8'h04, 8'h01);
                for (i = 1; i < RXT[m * 4 + k]; i++) sm.send(i[7:0]);
                wt(3);
                chk(32'h0, irq_o);
                sm.send(8'h55);
                wt(3);
                chk(32'h1, irq_o);
                wb(1'b1, 8'h08, 8'h03);
                rd(8'h28, 32'h0);
                if (m == 1) begin
                    sm.stall <= 1'b1;
                    wb(1'b1, 8'h08, {2'b00, k[1:0], 4'h1});
                    wb(1'b1, 8'h04, 8'h02);
                    for (i = 0; i < 128 - TXT[k]; i++) wb(1'b1, 8'h00, i[7:0]);
                    wt(3);
                    chk(32'h1, irq_o);
                    wb(1'b1, 8'h00, 8'h00);
                    wt(3);
                    chk(32'h0, irq_o);
                    wb(1'b1, 8'h08, 8'h05);
                    sm.stall <= 1'b0;
                    rd(8'h28, 32'h0);
                end
            end
        end
        // divisor latch behind the shared offsets
        wb(1'b1, 8'h0c, 8'h80);
        wb(1'b1, 8'h00, 8'h5a);
        wb(1'b1, 8'h04, 8'ha5);
        rd(8'h00, 32'h5a);
        rd(8'h04, 32'ha5);
        chk(32'ha55a, divisor_o);
        chk(32'h80, line_format_o);
        rd(8'h28, 32'h0);
        wb(1'b1, 8'h0c, 8'h00);
        rd(8'h04, 32'h02);
        // queueing off keeps a single byte
        wb(1'b1, 8'h08, 8'h00);
        sm.stall <= 1'b1;
        wb(1'b1, 8'h00, 8'h01);
        wb(1'b1, 8'h00, 8'h02);
        rd(8'h28, 32'h00010000);
        chk(32'h0, fifo_enable_o);
        // mid-run reset drops the held byte and clears the enables
        rst_i <= 1'b1;
        wt(2);
        rst_i <= 1'b0;
        wt(1);
        chk(32'h0, irq_o);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'hc1);
        rd(8'h28, 32'h0);
        close_out();
    end
endmodule // uhf_regs_bench

// ---- uhf_serial_model.sv ----
// byte stream partner standing for the serial receiver and transmitter
`timescale 1ns/1ps
module uhf_serial_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // receive stream into the block
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic rx_ready_i,
    // transmit stream out of the block
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    logic stall;
    logic [7:0] got[$];
    initial begin
        stall = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
    end
    // a stalled transmitter models a slow line
    assign tx_ready_o = !stall;
    always @(posedge clk_i) begin
        if (!rst_i && tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
        end
    end
    // offer one byte and hold it until taken
    task send(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        do @(posedge clk_i); while (rx_ready_i !== 1'b1);
        rx_valid_o <= 1'b0;
        // stale data must not pass for valid
        rx_data_o <= ~b;
    endtask
endmodule // uhf_serial_model
